// ==== src/cct_pkg.sv ====
// Shared constants and types for the four channel capture/compare timer
package cct_pkg;

	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int CCT_NCH = 4;
	localparam int CCT_AW  = 4;
	localparam int CCT_DW  = 16;

	// ************************************************************
	// Register offsets (word index on the plain register port)
	// ************************************************************
	localparam logic [3:0] CCT_OFS_CTRL  = 4'h0;
	localparam logic [3:0] CCT_OFS_DIR   = 4'h1;
	localparam logic [3:0] CCT_OFS_IEN   = 4'h2;
	localparam logic [3:0] CCT_OFS_MODE  = 4'h3;
	localparam logic [3:0] CCT_OFS_FORCE = 4'h4;
	localparam logic [3:0] CCT_OFS_CH3OV = 4'h5;
	localparam logic [3:0] CCT_OFS_FLAGS = 4'h6;
	localparam logic [3:0] CCT_OFS_COUNT = 4'h7;
	localparam logic [3:0] CCT_OFS_VAL0  = 4'h8;
	localparam logic [3:0] CCT_OFS_LATCH = 4'hc;
	localparam logic [3:0] CCT_OFS_PINS  = 4'hd;
	localparam logic [3:0] CCT_OFS_EDGE  = 4'he;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int CCT_CTRL_PRESC = 0;
	localparam int CCT_CTRL_CRE   = 3;
	localparam int CCT_CTRL_OVIE  = 4;
	localparam int CCT_CTRL_FFC   = 5;
	localparam int CCT_CTRL_EN    = 7;
	localparam int CCT_MODE_LEVEL = 0;
	localparam int CCT_MODE_MODE  = 4;
	localparam int CCT_CH3_MASK   = 0;
	localparam int CCT_CH3_DATA   = 4;
	localparam int CCT_FLAGS_OVF  = 7;
	localparam int CCT_PINS_OUT   = 0;
	localparam int CCT_PINS_OWN   = 4;
	localparam int CCT_PINS_IN    = 8;

	// ************************************************************
	// Reset values and counter limits
	// ************************************************************
	localparam logic [7:0]  CCT_EDGE_RST  = 8'h55;
	localparam logic [15:0] CCT_CNT_MAX   = 16'hffff;
	localparam logic [6:0]  CCT_PRESC_MAX = 7'h7f;

	// ************************************************************
	// Compare actions, coded as {mode bit, level bit}
	// ************************************************************
	localparam logic [1:0] CCT_ACT_OFF    = 2'b00;
	localparam logic [1:0] CCT_ACT_TOGGLE = 2'b01;
	localparam logic [1:0] CCT_ACT_CLEAR  = 2'b10;
	localparam logic [1:0] CCT_ACT_SET    = 2'b11;

	typedef struct packed {
		logic [2:0] prescale_select;
		logic       counter_reset_on_ch3;
		logic       overflow_irq_enable;
		logic       fast_flag_clear;
		logic       timer_enable;
	} cct_ctrl_t;

	typedef struct packed {
		cct_ctrl_t         ctrl;
		logic [3:0]        channel_direction_select;
		logic [3:0]        channel_irq_enable;
		logic [3:0]        compare_mode_bit;
		logic [3:0]        compare_level_bit;
		logic [3:0]        ch3_mask;
		logic [3:0]        ch3_data;
		logic [7:0]        edge_sel;
		logic [3:0]        channel_event_flag;
		logic              overflow_flag;
		logic [3:0]        port_latch;
		logic [3:0]        oc_state;
		logic [3:0]        cap_s1;
		logic [3:0]        cap_s2;
		logic [3:0]        cap_prev;
		logic [6:0]        presc;
		logic [15:0]       count;
		logic              stepped;
		logic              reset_pend;
		logic [3:0][15:0]  value;
		logic [15:0]       rdata;
		logic [3:0]        ch_irq;
		logic              ovf_irq;
		logic [3:0]        pin_out;
		logic [3:0]        pin_own;
	} cct_state_t;

endpackage

// ==== src/cct_timer.sv ====
// Four channel 16-bit capture/compare timer with plain register port
//
// Contract
// - Counter clocked by bus clock divided by 1 to 128 via prescale_select.
// - Direction bit zero makes the channel an input capture channel.
// - Active pin edge copies the counter into the channel value register.
// - Every input capture sets the channel event flag.
// - Channel interrupt follows its flag only while its enable is set.
// - Direction bit one makes the channel an output compare channel.
// - Counter equal to stored value sets, clears or toggles the pin.
// - Every normal compare match sets the channel event flag.
// - Mode and level bits pick the action; both zero disconnects the pin unless its channel 3 mask bit is set.
// - Force bit performs the compare action at once without a flag.
// - Channel 3 compare wins over simultaneous compares on other channels.
// - Channel 3 data reaches other pins only where its mask bit is set.
// - With counter reset enabled, channel 3 match returns counter to zero.
// - Port writes only load a latch that drives the pin outside compare use.
// - Four active-high channel interrupt outputs, one per channel.
// - Active-high overflow interrupt only while overflow enable is set.
// - Five interrupt requests in total: four channels and one overflow.
// - Overflow flag set when the counter wraps from all ones to zero.
// - Writing one clears an event or overflow flag; zero leaves it.
// - Fast clear: capture read, compare write or counter access clears flags.
// - Value register writes are ignored while the channel captures.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps

module cct_timer
	import cct_pkg::*;
(
	input  wire logic              CLOCK,
	input  wire logic              RST_N,
	input  wire logic [CCT_AW-1:0] ADDR,
	input  wire logic [CCT_DW-1:0] WDATA,
	input  wire logic              WR,
	input  wire logic              RD,
	output logic      [CCT_DW-1:0] RDATA,
	input  wire logic [3:0]        CAP_IN,
	output logic      [3:0]        PIN_OUT,
	output logic      [3:0]        PIN_CMP_OWN,
	output logic      [3:0]        CH_IRQ,
	output logic                   OVF_IRQ
);

	cct_state_t s_reg;
	cct_state_t s_next;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb
	begin
		logic [6:0]  lim;
		logic        tick;
		logic        reset_now;
		logic        ovf_set;
		logic        ovf_clr;
		logic [3:0]  match;
		logic [3:0]  cap_evt;
		logic [3:0]  force_act;
		logic [3:0]  flag_clr;
		logic [1:0]  act;
		logic [1:0]  vsel;
		logic        val_hit;
		s_next    = s_reg;
		lim       = 7'h00;
		tick      = 1'b0;
		reset_now = 1'b0;
		ovf_set   = 1'b0;
		ovf_clr   = 1'b0;
		match     = 4'h0;
		cap_evt   = 4'h0;
		force_act = 4'h0;
		flag_clr  = 4'h0;
		act       = CCT_ACT_OFF;
		vsel      = ADDR[1:0];
		val_hit   = (ADDR[3:2] == CCT_OFS_VAL0[3:2]);

		// Pin synchronisers; only the second stage feeds the edge logic
		s_next.cap_s1   = CAP_IN;
		s_next.cap_s2   = s_reg.cap_s1;
		s_next.cap_prev = s_reg.cap_s2;

		// Prescaler: limit is 2^sel - 1
		lim = CCT_PRESC_MAX >> (3'd7 - s_reg.ctrl.prescale_select);
		tick = s_reg.ctrl.timer_enable && (s_reg.presc >= lim);
		if (!s_reg.ctrl.timer_enable || tick)
		begin
			s_next.presc = 7'h00;
		end
		else
		begin
			s_next.presc = s_reg.presc + 7'h01;
		end

		// Matches are judged once per new counter value, so a slow
		// prescaler cannot fire the same compare many times
		for (int i = 0; i < CCT_NCH; i++)
		begin
			match[i] = s_reg.stepped && s_reg.channel_direction_select[i]
				&& (s_reg.count == s_reg.value[i]);
			cap_evt[i] = !s_reg.channel_direction_select[i] && (
				(s_reg.edge_sel[2*i] && s_reg.cap_s2[i] && !s_reg.cap_prev[i]) ||
				(s_reg.edge_sel[2*i+1] && !s_reg.cap_s2[i] && s_reg.cap_prev[i]));
		end

		// Counter
		reset_now = tick && (s_reg.reset_pend ||
			(match[3] && s_reg.ctrl.counter_reset_on_ch3));
		s_next.stepped = tick;
		if (reset_now)
		begin
			s_next.count      = 16'h0000;
			s_next.reset_pend = 1'b0;
		end
		else if (tick)
		begin
			s_next.count = s_reg.count + 16'h0001;
			ovf_set      = (s_reg.count == CCT_CNT_MAX);
		end
		if (match[3] && s_reg.ctrl.counter_reset_on_ch3 && !tick)
		begin
			// Prescaled tick not due yet: hold the reset for the next one
			s_next.reset_pend = 1'b1;
		end
		if (!s_reg.ctrl.counter_reset_on_ch3)
		begin
			s_next.reset_pend = 1'b0;
		end

		// Register writes
		if (WR)
		begin
			case (ADDR)
				CCT_OFS_CTRL:
				begin
					s_next.ctrl.prescale_select      = WDATA[CCT_CTRL_PRESC +: 3];
					s_next.ctrl.counter_reset_on_ch3 = WDATA[CCT_CTRL_CRE];
					s_next.ctrl.overflow_irq_enable  = WDATA[CCT_CTRL_OVIE];
					s_next.ctrl.fast_flag_clear      = WDATA[CCT_CTRL_FFC];
					s_next.ctrl.timer_enable         = WDATA[CCT_CTRL_EN];
				end
				CCT_OFS_DIR:
				begin
					s_next.channel_direction_select = WDATA[3:0];
				end
				CCT_OFS_IEN:
				begin
					s_next.channel_irq_enable = WDATA[3:0];
				end
				CCT_OFS_MODE:
				begin
					s_next.compare_level_bit = WDATA[CCT_MODE_LEVEL +: 4];
					s_next.compare_mode_bit  = WDATA[CCT_MODE_MODE +: 4];
				end
				CCT_OFS_FORCE:
				begin
					force_act = WDATA[3:0] & s_reg.channel_direction_select;
				end
				CCT_OFS_CH3OV:
				begin
					s_next.ch3_mask = WDATA[CCT_CH3_MASK +: 4];
					s_next.ch3_data = WDATA[CCT_CH3_DATA +: 4];
				end
				CCT_OFS_FLAGS:
				begin
					flag_clr = WDATA[3:0];
					ovf_clr  = WDATA[CCT_FLAGS_OVF];
				end
				CCT_OFS_COUNT:
				begin
					ovf_clr = s_reg.ctrl.fast_flag_clear;
				end
				CCT_OFS_LATCH:
				begin
					s_next.port_latch = WDATA[3:0];
				end
				CCT_OFS_EDGE:
				begin
					s_next.edge_sel = WDATA[7:0];
				end
				default:
				begin
					if (val_hit && s_reg.channel_direction_select[vsel])
					begin
						// Capture channels keep their stored value
						s_next.value[vsel] = WDATA;
						flag_clr[vsel] = s_reg.ctrl.fast_flag_clear;
					end
				end
			endcase
		end

		// Read side effects and read data, valid for one cycle only
		s_next.rdata = 16'h0000;
		if (RD)
		begin
			case (ADDR)
				CCT_OFS_CTRL:
				begin
					s_next.rdata[7:0] = {s_reg.ctrl.timer_enable, 1'b0,
						s_reg.ctrl.fast_flag_clear, s_reg.ctrl.overflow_irq_enable,
						s_reg.ctrl.counter_reset_on_ch3, s_reg.ctrl.prescale_select};
				end
				CCT_OFS_DIR:
				begin
					s_next.rdata[3:0] = s_reg.channel_direction_select;
				end
				CCT_OFS_IEN:
				begin
					s_next.rdata[3:0] = s_reg.channel_irq_enable;
				end
				CCT_OFS_MODE:
				begin
					s_next.rdata[7:0] = {s_reg.compare_mode_bit, s_reg.compare_level_bit};
				end
				CCT_OFS_CH3OV:
				begin
					s_next.rdata[7:0] = {s_reg.ch3_data, s_reg.ch3_mask};
				end
				CCT_OFS_FLAGS:
				begin
					s_next.rdata[CCT_FLAGS_OVF] = s_reg.overflow_flag;
					s_next.rdata[3:0]           = s_reg.channel_event_flag;
				end
				CCT_OFS_COUNT:
				begin
					s_next.rdata = s_reg.count;
					ovf_clr = ovf_clr | s_reg.ctrl.fast_flag_clear;
				end
				CCT_OFS_LATCH:
				begin
					s_next.rdata[3:0] = s_reg.port_latch;
				end
				CCT_OFS_PINS:
				begin
					s_next.rdata[CCT_PINS_OUT +: 4] = s_reg.pin_out;
					s_next.rdata[CCT_PINS_OWN +: 4] = s_reg.pin_own;
					s_next.rdata[CCT_PINS_IN +: 4]  = s_reg.cap_s2;
				end
				CCT_OFS_EDGE:
				begin
					s_next.rdata[7:0] = s_reg.edge_sel;
				end
				default:
				begin
					if (val_hit)
					begin
						s_next.rdata = s_reg.value[vsel];
						if (!s_reg.channel_direction_select[vsel])
						begin
							flag_clr[vsel] = flag_clr[vsel] | s_reg.ctrl.fast_flag_clear;
						end
					end
				end
			endcase
		end

		// Capture overrides nothing software can write (writes are ignored)
		for (int i = 0; i < CCT_NCH; i++)
		begin
			if (cap_evt[i])
			begin
				s_next.value[i] = s_reg.count;
			end
		end

		// Compare actions per channel
		for (int i = 0; i < CCT_NCH; i++)
		begin
			act = {s_reg.compare_mode_bit[i], s_reg.compare_level_bit[i]};
			if (match[i] || force_act[i])
			begin
				case (act)
					CCT_ACT_TOGGLE: s_next.oc_state[i] = !s_reg.oc_state[i];
					CCT_ACT_CLEAR:  s_next.oc_state[i] = 1'b0;
					CCT_ACT_SET:    s_next.oc_state[i] = 1'b1;
					default:        s_next.oc_state[i] = s_reg.oc_state[i];
				endcase
			end
		end

		// Channel 3 override is applied last so it wins any collision
		if (match[3] || force_act[3])
		begin
			for (int i = 0; i < CCT_NCH; i++)
			begin
				if (s_reg.ch3_mask[i] && s_reg.channel_direction_select[i])
				begin
					s_next.oc_state[i] = s_reg.ch3_data[i];
				end
			end
		end

		// Flags: a set in the same cycle as a clear wins
		s_next.channel_event_flag = (s_reg.channel_event_flag & ~flag_clr)
			| cap_evt | match;
		s_next.overflow_flag = (s_reg.overflow_flag && !ovf_clr) || ovf_set;

		// Interrupt outputs are registered on the same edge as the flags
		s_next.ch_irq  = s_next.channel_event_flag & s_next.channel_irq_enable;
		s_next.ovf_irq = s_next.overflow_flag && s_next.ctrl.overflow_irq_enable;

		// Pin ownership: compare logic only when an action or mask is set
		for (int i = 0; i < CCT_NCH; i++)
		begin
			s_next.pin_own[i] = s_next.channel_direction_select[i] &&
				(s_next.compare_mode_bit[i] || s_next.compare_level_bit[i]
				|| s_next.ch3_mask[i]);
			s_next.pin_out[i] = s_next.pin_own[i] ? s_next.oc_state[i]
				: s_next.port_latch[i];
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
		begin
			s_reg          <= '0;
			s_reg.edge_sel <= CCT_EDGE_RST;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign RDATA       = s_reg.rdata;
	assign PIN_OUT     = s_reg.pin_out;
	assign PIN_CMP_OWN = s_reg.pin_own;
	assign CH_IRQ      = s_reg.ch_irq;
	assign OVF_IRQ     = s_reg.ovf_irq;

endmodule

// ==== testbench/cct_pins.sv ====
// Far-side model: drives the capture pins with clean pulses
`timescale 1ns/1ps
module cct_pins
(
	input  wire logic       clk,
	input  wire logic [3:0] fire,
	output logic      [3:0] cap
);
	logic [2:0] n = 3'd0;
	initial cap = 4'h0;
	// Four cycles high so every pulse outlasts two bus clocks
	always @(posedge clk)
		if (fire != 4'h0)
		begin
			cap <= fire;
			n <= 3'd4;
		end
		else if (n != 3'd0)
		begin
			n <= n - 3'd1;
			if (n == 3'd1)
				cap <= 4'h0;
		end
endmodule

// ==== testbench/cct_timer_monitor.sv ====
// Port-level assertions for the capture/compare timer
`timescale 1ns/1ps
module cct_timer_monitor
	import cct_pkg::*;
(
	input wire logic              CLOCK,
	input wire logic              RST_N,
	input wire logic [CCT_AW-1:0] ADDR,
	input wire logic [CCT_DW-1:0] WDATA,
	input wire logic              WR,
	input wire logic              RD,
	input wire logic [CCT_DW-1:0] RDATA,
	input wire logic [3:0]        CAP_IN,
	input wire logic [3:0]        PIN_OUT,
	input wire logic [3:0]        PIN_CMP_OWN,
	input wire logic [3:0]        CH_IRQ,
	input wire logic              OVF_IRQ
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	sequence s_dir_off;
		WR && ADDR == CCT_OFS_DIR && WDATA[3:0] == 4'h0 ##1 !WR;
	endsequence
	property p_rd_idle;
		!RD |=> RDATA == 16'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_unmapped;
		RD && ADDR == 4'hf |=> RDATA == 16'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_force_rd;
		RD && ADDR == CCT_OFS_FORCE |=> RDATA == 16'h0;
	endproperty
	a_force_rd: assert property (p_force_rd) else $error("force reads back");
	property p_status;
		RD && ADDR == CCT_OFS_PINS |=> RDATA[7:0] == {$past(PIN_CMP_OWN), $past(PIN_OUT)};
	endproperty
	a_status: assert property (p_status) else $error("pin status wrong");
	property p_ien_off;
		WR && ADDR == CCT_OFS_IEN && WDATA[3:0] == 4'h0 |=> CH_IRQ == 4'h0;
	endproperty
	a_ien_off: assert property (p_ien_off) else $error("masked channel irq");
	property p_ovf_off;
		WR && ADDR == CCT_OFS_CTRL && !WDATA[CCT_CTRL_OVIE] |=> !OVF_IRQ;
	endproperty
	a_ovf_off: assert property (p_ovf_off) else $error("masked overflow irq");
	property p_own_off;
		s_dir_off |=> PIN_CMP_OWN == 4'h0;
	endproperty
	a_own_off: assert property (p_own_off) else $error("capture pin still owned");
	property p_sticky;
		!WR && !RD |=> ({$past(OVF_IRQ), $past(CH_IRQ)} & ~{OVF_IRQ, CH_IRQ}) == 5'h0;
	endproperty
	a_sticky: assert property (p_sticky) else $error("irq dropped by itself");
endmodule

bind cct_timer cct_timer_monitor i_mon (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CAP_IN(CAP_IN),
	.PIN_OUT(PIN_OUT), .PIN_CMP_OWN(PIN_CMP_OWN), .CH_IRQ(CH_IRQ), .OVF_IRQ(OVF_IRQ));

// ==== testbench/tb_top.sv ====
// Self-checking bench for the capture/compare timer
`timescale 1ns/1ps
module tb_top
	import cct_pkg::*;
;
	logic              CLOCK = 1'b0;
	logic              RST_N = 1'b0;
	logic [CCT_AW-1:0] ADDR = '0;
	logic [CCT_DW-1:0] WDATA = '0;
	logic              WR = 1'b0;
	logic              RD = 1'b0;
	logic              rd_q = 1'b0;
	logic [CCT_DW-1:0] RDATA;
	logic [3:0]        CAP_IN, PIN_OUT, PIN_CMP_OWN, CH_IRQ;
	logic [3:0]        fire = 4'h0;
	logic              OVF_IRQ;
	logic [15:0]       exp_q[$];
	logic [15:0]       v;
	int                mismatches = 0;
	int                n_compared = 0;
	int                k;

	always #2 CLOCK = ~CLOCK;

	cct_timer i_dut (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
		.WR(WR), .RD(RD), .RDATA(RDATA), .CAP_IN(CAP_IN), .PIN_OUT(PIN_OUT),
		.PIN_CMP_OWN(PIN_CMP_OWN), .CH_IRQ(CH_IRQ), .OVF_IRQ(OVF_IRQ));
	cct_pins i_pins (.clk(CLOCK), .fire(fire), .cap(CAP_IN));

	// ****************************************
	// Compare and close
	// ****************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		n_compared++;
		if (seen !== want)
		begin
			mismatches++;
			$display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
		end
	endtask

	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Read data is only valid in the cycle after the strobe
	always @(posedge CLOCK)
		rd_q <= RD;
	always @(negedge CLOCK)
		if (rd_q)
			check(RDATA, exp_q.pop_front());

	// ****************************************
	// Bus tasks
	// ****************************************
	// A spare cycle after each strobe keeps one assignment per time step
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLOCK);
		WR <= 1'b0;
		@(posedge CLOCK);
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLOCK);
		RD <= 1'b0;
		@(posedge CLOCK);
	endtask

	task automatic wait_for(input logic [4:0] m, input int lim);
		for (k = 0; k < lim && ({OVF_IRQ, CH_IRQ} & m) == 5'h0; k++)
			@(posedge CLOCK);
		if (k == lim)
		begin
			mismatches++;
			$display("MISMATCH t=%0t wait ran out", $time);
			close_out();
		end
	endtask

	initial
	begin
		void'($urandom(77654));
		repeat (16) @(posedge CLOCK);
		RST_N <= 1'b1;
		for (int a = 0; a < 16; a++)
			rd(a[3:0], (a[3:0] == CCT_OFS_EDGE) ? {8'h0, CCT_EDGE_RST} : 16'h0);
		v = 16'($urandom) | 16'h0001;
		wr(4'h9, v);
		rd(4'h9, 16'h0);
		wr(CCT_OFS_DIR, 16'h0007);
		wr(4'h9, v);
		rd(4'h9, v);
		wr(CCT_OFS_MODE, 16'h0077);
		wr(CCT_OFS_FORCE, 16'h0007);
		rd(CCT_OFS_PINS, 16'h0077);
		rd(CCT_OFS_FLAGS, 16'h0000);
		v = 16'h0040 + 16'($urandom % 64);
		wr(4'h8, v);
		wr(4'h9, v);
		wr(CCT_OFS_MODE, 16'h0021);
		wr(CCT_OFS_LATCH, 16'h0005);
		rd(CCT_OFS_PINS, 16'h0037);
		wr(CCT_OFS_IEN, 16'h0001);
		wr(CCT_OFS_CTRL, 16'h0080);
		wait_for(5'h01, 400);
		wr(CCT_OFS_CTRL, 16'h0000);
		rd(CCT_OFS_PINS, 16'h0034);
		rd(CCT_OFS_FLAGS, 16'h0003);
		check({12'h0, CH_IRQ}, 16'h0001);
		wr(CCT_OFS_FLAGS, 16'h0001);
		rd(CCT_OFS_FLAGS, 16'h0002);
		wr(CCT_OFS_FLAGS, 16'h00ff);
		wr(CCT_OFS_IEN, 16'h0008);
		fire <= 4'h9;
		@(posedge CLOCK);
		fire <= 4'h0;
		wait_for(5'h08, 20);
		check({12'h0, CH_IRQ}, 16'h0008);
		rd(CCT_OFS_FLAGS, 16'h0008);
		wr(CCT_OFS_DIR, 16'h0000);
		wr(CCT_OFS_FLAGS, 16'h00ff);
		wr(CCT_OFS_CTRL, 16'h0090);
		wait_for(5'h10, 70000);
		rd(CCT_OFS_FLAGS, 16'h0080);
		wr(CCT_OFS_CTRL, 16'h0000);
		check({15'h0, OVF_IRQ}, 16'h0000);
		rd(CCT_OFS_FLAGS, 16'h0080);
		// Channel 3 override on masked pins, counter reset on match, fast clear
		wr(CCT_OFS_DIR, 16'h000f);
		wr(4'ha, 16'hffff);
		wr(4'hb, 16'h0200);
		wr(CCT_OFS_MODE, 16'h0080);
		wr(CCT_OFS_CH3OV, 16'h0033);
		wr(CCT_OFS_CTRL, 16'h00a8);
		wait_for(5'h08, 1000);
		wr(CCT_OFS_CTRL, 16'h0020);
		rd(CCT_OFS_PINS, 16'h00b7);
		rd(CCT_OFS_COUNT, 16'h0002);
		rd(CCT_OFS_FLAGS, 16'h000b);
		close_out();
	end
endmodule
